// >>> pwm_mode_chk_checker.sv
// Checker for the power-mode clocking block
`timescale 1ns/100ps
`default_nettype none
module pwm_mode_chk(input wire logic sys_clk_i, arst_n_i, sleep_i, fail_monitor_en_i,
    pri_clk_fail_i, pwm_o, pwm_oe_o, internal_mode_a_o, input wire logic [7:0] period_timer_o,
    peripheral_flag_register_two_o, input wire logic [2:0] clk_src_o);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence fail_s;
        fail_monitor_en_i && pri_clk_fail_i && !sleep_i ##1 !sleep_i;
    endsequence
    AST_SLEEP_TMR: assert property (sleep_i |=> $stable(period_timer_o))
        else $error("timer moved in sleep");
    AST_SLEEP_PIN: assert property (sleep_i |=> $stable(pwm_o) && $stable(pwm_oe_o))
        else $error("pin changed in sleep");
    AST_FAIL: assert property (fail_s |-> peripheral_flag_register_two_o[7]
        && internal_mode_a_o ##[1:16] clk_src_o == 3'h4)
        else $error("failure not handled");
    AST_MODE_HOLD: assert property (internal_mode_a_o |=> internal_mode_a_o)
        else $error("internal mode dropped");
    AST_FLAG_ZERO: assert property (peripheral_flag_register_two_o[6:0] == 7'h00)
        else $error("flag bits set");
    AST_ONEHOT: assert property ($onehot(clk_src_o))
        else $error("source not one-hot");
    AST_RST_PIN: assert property ($rose(arst_n_i) |-> !pwm_oe_o && !pwm_o)
        else $error("pin driven after reset");
    AST_RST_REG: assert property ($rose(arst_n_i) |-> period_timer_o == 8'h00
        && clk_src_o == 3'h1 && peripheral_flag_register_two_o == 8'h00)
        else $error("bad reset state");
endmodule // pwm_mode_chk
bind pwm_power_mode_clocking pwm_mode_chk u_chk(.*);
`default_nettype wire

// >>> pwm_power_mode_clocking.v
// Clock source selection, sleep freeze and reset behaviour of the capture/PWM unit
`timescale 1ns/100ps
`default_nettype none
`include "pwm_power_mode_clocking_defines.vh"

module pwm_power_mode_clocking (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire sleep_i,
    input wire [1:0] power_mode_i,
    input wire pri_tick_i,
    input wire pm_tick_i,
    input wire internal_oscillator_source_tick_i,
    input wire fail_monitor_en_i,
    input wire pri_clk_fail_i,
    input wire osc_fail_flag_clr_i,
    input wire timer_on_i,
    input wire [7:0] period_i,
    input wire [7:0] duty_i,
    input wire pwm_drive_en_i,
    output wire [7:0] period_timer_o,
    output wire period_match_o,
    output wire pwm_o,
    output wire pwm_oe_o,
    output wire [7:0] peripheral_flag_register_two_o,
    output wire internal_mode_a_o,
    output wire [2:0] clk_src_o
);

    reg [2:0] src_q;
    reg [2:0] src_d;
    reg [7:0] tmr_q;
    reg [7:0] tmr_d;
    reg match_q;
    reg match_d;
    reg pwm_q;
    reg pwm_d;
    reg oe_q;
    reg oe_d;
    reg fail_flag_q;
    reg fail_flag_d;
    reg int_mode_q;
    reg int_mode_d;
    reg src_tick;
    reg [2:0] want_src;
    wire count_en;
    wire at_period;
    wire fail_seen;

    // Timer advances only on a tick of the source now in use
    assign count_en = timer_on_i && src_tick;
    // Last count of a period
    assign at_period = (tmr_q == period_i);
    // Failure is recognised in sleep as well
    assign fail_seen = fail_monitor_en_i && pri_clk_fail_i;

    ////////////////////////////////////////////////////////////////////////////
    // Clock source selection

    always @* begin
        if (int_mode_q) begin
            want_src = `SRC_INT;
        end else if (power_mode_i == `PM_RUN_PRIMARY || power_mode_i == `PM_PRIMARY_IDLE) begin
            want_src = `SRC_PRI;
        end else begin
            want_src = `SRC_PM;
        end
    end

    always @* begin
        case (src_q)
            `SRC_PRI: src_tick = pri_tick_i;
            `SRC_PM: src_tick = pm_tick_i;
            `SRC_INT: src_tick = internal_oscillator_source_tick_i;
            default: src_tick = 1'b0;
        endcase
    end

    // Hand over only on a tick of the old source; a failed primary
    // delivers no more ticks, so that case hands over at once
    always @* begin
        src_d = src_q;
        if (want_src != src_q) begin
            if (src_tick || (int_mode_q && src_q == `SRC_PRI)) begin
                src_d = want_src;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Period timer

    always @* begin
        tmr_d = tmr_q;
        if (count_en) begin
            if (at_period) begin
                tmr_d = `TIMER_RST;
            end else begin
                tmr_d = tmr_q + 8'h01;
            end
        end
    end

    // Match pulses for one cycle on the wrap
    always @* begin
        match_d = 1'b0;
        if (count_en && at_period) begin
            match_d = 1'b1;
        end
    end

    // Level is refreshed only on a counted tick
    always @* begin
        pwm_d = pwm_q;
        if (count_en) begin
            pwm_d = (tmr_d < duty_i);
        end
    end

    // Direction request takes effect one cycle later
    always @* begin
        oe_d = pwm_drive_en_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers; sleep holds all of them except match_q, which it clears

    // Active source survives sleep
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            src_q <= `SRC_PRI;
        end else if (!sleep_i) begin
            src_q <= src_d;
        end
    end

    // Count is frozen in sleep and resumes from where it stood
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tmr_q <= `TIMER_RST;
        end else if (!sleep_i) begin
            tmr_q <= tmr_d;
        end
    end

    // No match can be reported while nothing counts
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            match_q <= 1'b0;
        end else if (sleep_i) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_d;
        end
    end

    // Driven level is kept through sleep
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pwm_q <= 1'b0;
        end else if (!sleep_i) begin
            pwm_q <= pwm_d;
        end
    end

    // Reset turns the pin to an input
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            oe_q <= 1'b0;
        end else if (!sleep_i) begin
            oe_q <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock failure handling

    // A failure in the same cycle as a clear keeps the flag set
    always @* begin
        fail_flag_d = fail_flag_q;
        if (fail_seen) begin
            fail_flag_d = 1'b1;
        end else if (osc_fail_flag_clr_i) begin
            fail_flag_d = 1'b0;
        end
    end

    // Internal mode is left only by a reset
    always @* begin
        int_mode_d = int_mode_q | fail_seen;
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fail_flag_q <= 1'b0;
        end else begin
            fail_flag_q <= fail_flag_d;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            int_mode_q <= 1'b0;
        end else begin
            int_mode_q <= int_mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs come straight from registers

    assign period_timer_o = tmr_q;
    assign period_match_o = match_q;
    assign pwm_o = pwm_q;
    assign pwm_oe_o = oe_q;
    assign peripheral_flag_register_two_o = {fail_flag_q, 7'h00};
    assign internal_mode_a_o = int_mode_q;
    assign clk_src_o = src_q;

endmodule // pwm_power_mode_clocking
`default_nettype wire

// >>> pwm_power_mode_clocking_defines.vh
// Constants for the power-mode clocking of the enhanced capture/PWM unit
// Summary of operation
// - Sleep freezes period timer and unit state, but not the failure flag or internal mode
// - Driven pins keep their level during sleep
// - Wake resumes from frozen state, no reinit
// - Primary idle keeps primary clock unchanged
// - Other power modes clock timer from mode clock
// - Clock failure enters internal mode, sets flag bit 7
// - After failure unit runs from internal oscillator
// - Every reset turns pins to inputs
// - Reset restores basic-compatible register defaults
`ifndef PWM_POWER_MODE_CLOCKING_DEFINES_VH
`define PWM_POWER_MODE_CLOCKING_DEFINES_VH

`define PM_RUN_PRIMARY 2'h0
`define PM_PRIMARY_IDLE 2'h1
`define PM_OTHER 2'h2
`define PM_OTHER_IDLE 2'h3

`define SRC_PRI 3'h1
`define SRC_PM 3'h2
`define SRC_INT 3'h4

`define FLAG_REG_W 8
`define OSC_FAIL_BIT 7
`define TIMER_W 8
`define TIMER_RST 8'h00
`define FLAG_REG_RST 8'h00

`endif

// >>> pwm_power_mode_clocking_tb.sv
// Self-checking bench for the power-mode clocking block
`timescale 1ns/100ps
`default_nettype none
module pwm_power_mode_clocking_tb;
    logic clk = 0, rst_n = 0, slp = 0, pt = 0, mt = 0, it = 0, on = 0, fe = 0, pf = 0, den = 0;
    logic eo = 0, ep = 0, ef = 0, have = 0, oe, pw, mat, imode;
    logic [1:0] pm = 0;
    logic [2:0] es = 1, src;
    logic [7:0] e = 0, tmr, flg;
    logic [22:0] nx, q[$];
    int failures = 0, n_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    pwm_power_mode_clocking DUT(.sys_clk_i(clk), .arst_n_i(rst_n), .sleep_i(slp),
        .power_mode_i(pm), .pri_tick_i(pt), .pm_tick_i(mt), .internal_oscillator_source_tick_i(it),
        .fail_monitor_en_i(fe), .pri_clk_fail_i(pf), .osc_fail_flag_clr_i(1'b0),
        .timer_on_i(on), .period_i(8'h05), .duty_i(8'h03), .pwm_drive_en_i(den),
        .period_timer_o(tmr), .period_match_o(mat), .pwm_o(pw), .pwm_oe_o(oe),
        .peripheral_flag_register_two_o(flg), .internal_mode_a_o(imode), .clk_src_o(src));
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [22:0] a, input logic [22:0] x);
        n_checks++;
        if (a !== x) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, a, x);
        end
    endtask
    always @(negedge clk) begin
        cyc++;
        if (q.size() > 0) cmp({mat, pw, oe, src, tmr, flg, imode}, q.pop_front());
        if (cyc > 1000) begin
            failures++;
            end_of_test();
        end
    end
    // Notes for one edge's inputs are queued at the following edge
    task automatic step(input bit chk);
        logic [3:0] r;
        bit t;
        bit m;
        @(posedge clk);
        if (have) q.push_back(nx);
        r = chk ? 4'($urandom) : 4'h7;
        pt <= r[0];
        mt <= r[1];
        it <= r[2];
        slp <= r[3];
        on <= chk;
        t = !r[3] && chk && r[es == 3'h1 ? 0 : es == 3'h2 ? 1 : 2];
        m = t && (e == 8'h05);
        if (t) begin
            e = (e == 8'h05) ? 8'h00 : e + 8'h01;
            ep = (e < 8'h03);
        end
        if (!r[3]) eo = 1'b1;
        if (fe && pf) ef = 1'b1;
        nx = {m, ep, eo, es, e, ef, 7'h00, ef};
        have = chk;
    endtask
    // Mode changes only after the last note of the previous mode is taken
    task automatic run(input logic [1:0] m, input logic [2:0] s);
        step(0);
        pm <= m;
        step(0);
        es = s;
        repeat (40) step(1);
        $display("mode %0d done", m);
    endtask
    initial begin
        void'($urandom(97));
        repeat (4) @(posedge clk);
        rst_n <= 1;
        den <= 1;
        run(2'h0, 3'h1);
        run(2'h1, 3'h1);
        run(2'h2, 3'h2);
        step(0);
        fe <= 1;
        pf <= 1;
        run(2'h3, 3'h4);
        step(0);
        step(0);
        rst_n <= 0;
        fe <= 0;
        pf <= 0;
        pm <= 2'h0;
        @(posedge clk);
        rst_n <= 1;
        e = 8'h00;
        es = 3'h1;
        eo = 1'b0;
        ep = 1'b0;
        ef = 1'b0;
        run(2'h0, 3'h1);
        step(0);
        @(posedge clk);
        end_of_test();
    end
endmodule // pwm_power_mode_clocking_tb
`default_nettype wire
